// ### flash_reset_sleep_autoselect_test.sv
// Self-checking bench for the boot-sector flash host controller
`include "frs_map.svh"
module flash_reset_sleep_autoselect_test;
  timeunit 1ns;
  timeprecision 1ps;
  import frs_pkg::*;
  typedef struct {frs_op_t op; frs_id_sel_t sel; logic [18:0] addr; logic bm; logic top;
    logic [15:0] exp;} frs_tb_row_t;
  localparam int RESET_PULSE_MIN_CYC = `FRS_RESET_PULSE_MIN_NS / `FRS_CLK_NS;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic en_i = 1'b1;
  logic cmd_valid_i = 1'b0, byte_mode_i = 1'b0, boot_top_i = 1'b0, restart_ack_i = 1'b0;
  frs_op_t cmd_op_i = FRS_OP_READ;
  frs_id_sel_t cmd_id_sel_i = FRS_ID_MAKER;
  logic [18:0] cmd_addr_i = 19'h00000;
  logic [15:0] cmd_wdata_i = 16'h0000;
  logic [15:0] dq_i, rdata_o, dq_o, dq_oe_o;
  logic [17:0] addr_o;
  logic [3:0] sector_o;
  logic ready_busy_i, ready_o, done_o, restart_needed_o, ce_n_o, oe_n_o, we_n_o;
  logic flash_rst_n_o, byte_n_o, id_voltage_en_o, busy_go = 1'b0, early_done = 1'b0;
  int bad_count = 0, n_tests = 0, low_cnt = 0;
  frs_tb_row_t rows[9];
  frs_host #(.TRDY_BUSY_NS(1000)) DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .en_i(en_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_id_sel_i(cmd_id_sel_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .byte_mode_i(byte_mode_i),
    .boot_top_i(boot_top_i), .restart_ack_i(restart_ack_i), .dq_i(dq_i),
    .ready_busy_i(ready_busy_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .sector_o(sector_o), .restart_needed_o(restart_needed_o), .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o), .we_n_o(we_n_o), .flash_rst_n_o(flash_rst_n_o), .byte_n_o(byte_n_o),
    .id_voltage_en_o(id_voltage_en_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  frs_flash_model u_flash (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .rst_n_i(flash_rst_n_o), .byte_n_i(byte_n_o), .id_hv_i(id_voltage_en_o),
    .busy_go_i(busy_go), .addr_i(addr_o), .dq_i(dq_o), .dq_o(dq_i),
    .ready_busy_o(ready_busy_i));
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (flash_rst_n_o === 1'b0) low_cnt <= low_cnt + 1;
    if (done_o === 1'b1 && ready_busy_i !== 1'b1) early_done <= 1'b1;
  end
  function automatic logic [15:0] arr_exp(input logic [18:0] a, input logic bm);
    logic [15:0] w;
    w = (bm ? a[16:1] : a[15:0]) ^ 16'hA5C3;
    return bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
  endfunction : arr_exp
  function automatic logic [3:0] sec_exp(input logic top, input logic [5:0] a);
    if (top) begin
      if (a[5:3] != 3'h7) return {1'b0, a[5:3]};
      if (!a[2]) return 4'h7;
      if (!a[1]) return a[0] ? 4'h9 : 4'h8;
      return 4'hA;
    end
    if (a[5:3] != 3'h0) return {1'b0, a[5:3]} + 4'h3;
    if (a[2]) return 4'h3;
    if (!a[1]) return 4'h0;
    return a[0] ? 4'h2 : 4'h1;
  endfunction : sec_exp
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic run(input frs_op_t op, input frs_id_sel_t sel, input logic [18:0] a,
      input logic bm, input logic top);
    int n;
    @(posedge sys_clk_i);
    cmd_op_i <= op;
    cmd_id_sel_i <= sel;
    cmd_addr_i <= a;
    byte_mode_i <= bm;
    boot_top_i <= top;
    cmd_wdata_i <= 16'h1234;
    cmd_valid_i <= 1'b1;
    do @(posedge sys_clk_i); while (ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 4000) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 4000) begin
      bad_count++;
      $display("MISMATCH done expected 1 seen %b", done_o);
      results();
    end
  endtask : run
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    #300000;
    bad_count++;
    results();
  end
  initial begin
    rows[0] = '{FRS_OP_READ, FRS_ID_MAKER, 19'h08123, 1'b0, 1'b0, arr_exp(19'h08123, 1'b0)};
    rows[1] = '{FRS_OP_READ, FRS_ID_MAKER, 19'h7C247, 1'b1, 1'b1, arr_exp(19'h7C247, 1'b1)};
    rows[2] = '{FRS_OP_ID_HV, FRS_ID_MAKER, 19'h00000, 1'b0, 1'b0, 16'h003C};
    rows[3] = '{FRS_OP_ID_HV, FRS_ID_PART, 19'h00000, 1'b0, 1'b1, 16'h006D};
    rows[4] = '{FRS_OP_ID_HV, FRS_ID_PROTECT, 19'h3F000, 1'b0, 1'b0, 16'h0001};
    rows[5] = '{FRS_OP_ID_CMD, FRS_ID_MAKER, 19'h00000, 1'b1, 1'b0, 16'h003C};
    rows[6] = '{FRS_OP_ID_CMD, FRS_ID_PART, 19'h00000, 1'b1, 1'b0, 16'h006D};
    rows[7] = '{FRS_OP_ID_CMD, FRS_ID_PROTECT, 19'h00000, 1'b0, 1'b0, 16'h0000};
    rows[8] = '{FRS_OP_READ, FRS_ID_MAKER, 19'h3D456, 1'b0, 1'b1, arr_exp(19'h3D456, 1'b0)};
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk_val("idle_pins", 16'h000F, {12'h000, ce_n_o, oe_n_o, we_n_o, flash_rst_n_o});
    chk_val("idle_dq_oe", 16'h0000, dq_oe_o);
    $display("test idle done");
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].sel, rows[i].addr, rows[i].bm, rows[i].top);
      chk_val("rdata", rows[i].exp, rdata_o);
      if (rows[i].op == FRS_OP_READ) begin
        chk_val("sector", {12'h000, sec_exp(rows[i].top, rows[i].bm ? rows[i].addr[18:13] :
          rows[i].addr[17:12])}, {12'h000, sector_o});
      end
      $display("test row %0d done", i);
    end
    // Idle hardware reset: pulse length, no restart, then a clean array read
    low_cnt = 0;
    run(FRS_OP_HWRESET, FRS_ID_MAKER, 19'h00000, 1'b0, 1'b0);
    chk_bit("rst_pulse_min", 1'b1, low_cnt >= RESET_PULSE_MIN_CYC);
    chk_bit("restart_idle", 1'b0, restart_needed_o);
    run(FRS_OP_READ, FRS_ID_MAKER, 19'h08123, 1'b0, 1'b0);
    chk_val("read_after_rst", arr_exp(19'h08123, 1'b0), rdata_o);
    $display("test idle reset done");
    // Reset while the device is busy with an embedded operation
    busy_go <= 1'b1;
    @(posedge sys_clk_i);
    busy_go <= 1'b0;
    run(FRS_OP_HWRESET, FRS_ID_MAKER, 19'h00000, 1'b0, 1'b0);
    chk_bit("restart_flag", 1'b1, restart_needed_o);
    chk_bit("early_done", 1'b0, early_done);
    run(FRS_OP_WRITE, FRS_ID_MAKER, 19'h00100, 1'b0, 1'b0);
    restart_ack_i <= 1'b1;
    @(posedge sys_clk_i);
    restart_ack_i <= 1'b0;
    @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    chk_bit("restart_clear", 1'b0, restart_needed_o);
    $display("test busy reset done");
    // Frozen by the clock enable, a waiting request must not start a bus cycle
    en_i <= 1'b0;
    cmd_op_i <= FRS_OP_READ;
    cmd_valid_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk_bit("freeze_ce", 1'b1, ce_n_o);
    en_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    chk_bit("read_running", 1'b0, oe_n_o);
    // Reset pulled in the middle of that read puts every pin back to idle
    cmd_valid_i <= 1'b0;
    reset_n_i <= 1'b0;
    @(posedge sys_clk_i);
    chk_val("mid_rst_pins", 16'h000F, {12'h000, ce_n_o, oe_n_o, we_n_o, flash_rst_n_o});
    chk_bit("mid_rst_ready", 1'b1, ready_o);
    reset_n_i <= 1'b1;
    run(FRS_OP_READ, FRS_ID_MAKER, 19'h08123, 1'b0, 1'b0);
    chk_val("read_after_mid", arr_exp(19'h08123, 1'b0), rdata_o);
    $display("test enable and mid reset done");
    results();
  end
endmodule : flash_reset_sleep_autoselect_test

// ### frs_flash_model.sv
// Behavioural pin model of the boot-sector flash that the host controller drives
module frs_flash_model #(
  parameter int ACC_NS = 80,
  parameter int RDY_BUSY_NS = 600,
  parameter int RH_NS = 40,
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h6D, // Arbitrary value
  parameter logic [7:0] PART_HI = 8'h7E // Arbitrary value
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rst_n_i,
  input wire logic byte_n_i,
  input wire logic id_hv_i,
  input wire logic busy_go_i,
  input wire logic [17:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic ready_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] word_val;
  logic [15:0] raw_val;
  logic [15:0] acc_val;
  logic [15:0] last_q;
  logic [1:0] unlock_q;
  logic asel_q;
  logic busy_q;
  logic rh_ok_q;
  logic drive;
  initial begin
    unlock_q = 2'h0;
    asel_q = 1'b0;
    busy_q = 1'b0;
    rh_ok_q = 1'b1;
    last_q = 16'h0000;
  end
  // Reads are honoured only when selected, gated, out of reset and past the recovery time
  assign drive = !ce_n_i && !oe_n_i && rst_n_i && rh_ok_q;
  always_comb begin
    if (asel_q || id_hv_i) begin
      if (addr_i[0]) word_val = {PART_HI, PART_CODE};
      else if (addr_i[1]) word_val = {15'h0000, &addr_i[17:15]};
      else word_val = {8'h00, MAKER_CODE};
    end else begin
      word_val = addr_i[15:0] ^ 16'hA5C3;
    end
    raw_val = word_val;
    if (!byte_n_i) begin
      // Upper lines float in byte mode, so they show junk rather than data
      raw_val[15:8] = ~word_val[15:8];
      if (dq_i[15] && !asel_q && !id_hv_i) raw_val[7:0] = word_val[15:8];
    end
  end
  // Data follows the address after the access delay and stays put while it is still
  assign #(ACC_NS) acc_val = raw_val;
  assign dq_o = drive ? acc_val : ~last_q;
  always @(acc_val or drive) begin
    if (drive) last_q = acc_val;
  end
  // Command decode; writes only count while selected and out of reset
  always @(negedge we_n_i) begin
    #1;
    if (!ce_n_i && rst_n_i) begin
      if (dq_i[7:0] == 8'hF0) begin
        asel_q = 1'b0;
        unlock_q = 2'h0;
      end else if (unlock_q == 2'h0) begin
        unlock_q = (addr_i[10:0] == 11'h555 && dq_i[7:0] == 8'hAA) ? 2'h1 : 2'h0;
      end else if (unlock_q == 2'h1) begin
        unlock_q = (addr_i[10:0] == 11'h2AA && dq_i[7:0] == 8'h55) ? 2'h2 : 2'h0;
      end else begin
        asel_q = (addr_i[10:0] == 11'h555 && dq_i[7:0] == 8'h90);
        unlock_q = 2'h0;
      end
    end
  end
  always @(posedge busy_go_i) busy_q = 1'b1;
  always @(negedge rst_n_i) begin
    rh_ok_q = 1'b0;
    asel_q = 1'b0;
    unlock_q = 2'h0;
    if (busy_q) busy_q <= #(RDY_BUSY_NS) 1'b0;
  end
  // Idle reset completes well inside the recovery wait, so ready stays high
  always @(posedge rst_n_i) rh_ok_q <= #(RH_NS) 1'b1;
  assign ready_busy_o = !busy_q;
endmodule : frs_flash_model

// ### frs_host.sv
// Host controller driving the pins of a parallel boot-sector flash
`include "frs_map.svh"
module frs_host #(
  parameter int unsigned ACCESS_DELAY_NS = `FRS_ACCESS_DELAY_NS,
  parameter int unsigned RESET_PULSE_MIN_NS = `FRS_RESET_PULSE_MIN_NS,
  parameter int unsigned RESET_HIGH_TO_READ_NS = `FRS_RESET_HIGH_TO_READ_NS,
  parameter int unsigned TRDY_BUSY_NS = `FRS_TRDY_BUSY_NS,
  parameter int unsigned TRDY_IDLE_NS = `FRS_TRDY_IDLE_NS,
  parameter int unsigned TWP_NS = `FRS_TWP_NS,
  parameter int unsigned TWPH_NS = `FRS_TWPH_NS
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic cmd_valid_i,
  input wire frs_pkg::frs_op_t cmd_op_i,
  input wire frs_pkg::frs_id_sel_t cmd_id_sel_i,
  input wire logic [18:0] cmd_addr_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic byte_mode_i,
  input wire logic boot_top_i,
  input wire logic restart_ack_i,
  input wire logic [15:0] dq_i,
  input wire logic ready_busy_i,
  output logic ready_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic [3:0] sector_o,
  output logic restart_needed_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic flash_rst_n_o,
  output logic byte_n_o,
  output logic id_voltage_en_o,
  output logic [17:0] addr_o,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe_o
);
  import frs_pkg::*;

  function automatic logic [15:0] min_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + `FRS_CLK_NS - 1) / `FRS_CLK_NS;
    if (c < 1) c = 1;
    return c[15:0];
  endfunction : min_cyc

  localparam logic [15:0] ACCESS_DELAY_CYC = min_cyc(ACCESS_DELAY_NS);
  localparam logic [15:0] RESET_PULSE_MIN_CYC = min_cyc(RESET_PULSE_MIN_NS);
  localparam logic [15:0] RESET_HIGH_TO_READ_CYC = min_cyc(RESET_HIGH_TO_READ_NS);
  localparam logic [15:0] TRDY_BUSY_CYC = min_cyc(TRDY_BUSY_NS);
  localparam logic [15:0] TRDY_IDLE_CYC = min_cyc(TRDY_IDLE_NS);
  localparam logic [15:0] TWP_CYC = min_cyc(TWP_NS);
  localparam logic [15:0] TWPH_CYC = min_cyc(TWPH_NS);

  // Bus address: [18:1] are A17..A0, [0] is A-1 (only meaningful in byte mode)
  function automatic logic [18:0] to_bus(input logic [18:0] a, input logic bm);
    return bm ? a : {a[17:0], 1'b0};
  endfunction : to_bus

  function automatic logic [18:0] id_addr(input frs_id_sel_t s, input logic [18:0] a);
    logic [2:0] off;
    off = `FRS_ID_MAKER_OFF;
    if (s == FRS_ID_PART) off = `FRS_ID_PART_OFF;
    if (s == FRS_ID_PROTECT) off = `FRS_ID_PROT_OFF;
    return {a[18:`FRS_SECTOR_SELECT_LSB], 10'h000, off};
  endfunction : id_addr

  function automatic frs_cycle_t cyc_of(input frs_op_t op, input logic [2:0] step,
                                        input frs_id_sel_t s, input logic [18:0] ba,
                                        input logic [7:0] wd);
    frs_cycle_t c;
    c = '{wr: 1'b0, addr: ba, data: wd, last: 1'b1};
    if (op == FRS_OP_WRITE) c.wr = 1'b1;
    if (op == FRS_OP_ID_HV) c.addr = id_addr(s, ba);
    if (op == FRS_OP_ID_CMD) begin
      c.last = 1'b0;
      c.wr = 1'b1;
      unique case (step)
        // Unlock addresses are word addresses; in byte mode A-1 stays low
        3'h0: begin
          c.addr = to_bus({1'b0, `FRS_UNLOCK_ADDR1}, 1'b0);
          c.data = `FRS_UNLOCK_DATA1;
        end
        3'h1: begin
          c.addr = to_bus({1'b0, `FRS_UNLOCK_ADDR2}, 1'b0);
          c.data = `FRS_UNLOCK_DATA2;
        end
        3'h2: begin
          c.addr = to_bus({1'b0, `FRS_UNLOCK_ADDR1}, 1'b0);
          c.data = `FRS_AUTOSEL_DATA;
        end
        3'h3: begin
          c.wr = 1'b0;
          c.addr = id_addr(s, ba);
        end
        default: begin
          // Device holds autoselect until this exit command
          c.data = `FRS_EXIT_DATA;
          c.last = 1'b1;
        end
      endcase
    end
    return c;
  endfunction : cyc_of

  frs_state_t st_r, st_nxt;
  frs_op_t op_r, op_nxt;
  frs_id_sel_t sel_r, sel_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [2:0] step_r, step_nxt;
  logic [18:0] ba_r, ba_nxt;
  logic [15:0] wd_r, wd_nxt, rdata_nxt, dq_nxt, dq_oe_nxt;
  logic bm_r, bm_nxt, busy_rst_r, busy_rst_nxt;
  logic done_nxt, ready_nxt, restart_nxt, ce_nxt, oe_nxt, we_nxt, frst_nxt, idv_nxt;
  logic [3:0] sector_nxt, sector_dec;
  logic [17:0] addr_nxt;
  frs_cycle_t cyc;

  frs_sector_decode u_dec (
    .boot_top_i(boot_top_i),
    .sector_select_address_i(ba_r[18:`FRS_SECTOR_SELECT_LSB]),
    .sector_o(sector_dec)
  );

  always_comb begin
    cyc = cyc_of(op_r, step_r, sel_r, ba_r, wd_r[7:0]);
    st_nxt = st_r;
    op_nxt = op_r;
    sel_nxt = sel_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    ba_nxt = ba_r;
    wd_nxt = wd_r;
    bm_nxt = bm_r;
    busy_rst_nxt = busy_rst_r;
    rdata_nxt = rdata_o;
    done_nxt = 1'b0;
    // Set wins over the acknowledge so a cut operation is never lost
    restart_nxt = restart_needed_o & ~restart_ack_i;
    ce_nxt = ce_n_o;
    oe_nxt = oe_n_o;
    we_nxt = we_n_o;
    frst_nxt = flash_rst_n_o;
    idv_nxt = id_voltage_en_o;
    addr_nxt = addr_o;
    dq_nxt = dq_o;
    dq_oe_nxt = dq_oe_o;
    sector_nxt = sector_dec;
    unique case (st_r)
      FRS_ST_IDLE: begin
        if (cmd_valid_i) begin
          op_nxt = cmd_op_i;
          sel_nxt = cmd_id_sel_i;
          ba_nxt = to_bus(cmd_addr_i, byte_mode_i);
          wd_nxt = cmd_wdata_i;
          bm_nxt = byte_mode_i;
          step_nxt = 3'h0;
          if (cmd_op_i == FRS_OP_HWRESET) begin
            frst_nxt = 1'b0;
            cnt_nxt = RESET_PULSE_MIN_CYC;
            busy_rst_nxt = ~ready_busy_i;
            if (!ready_busy_i) restart_nxt = 1'b1;
            st_nxt = FRS_ST_RST_LOW;
          end else begin
            st_nxt = FRS_ST_BUS;
          end
        end
      end
      FRS_ST_BUS: begin
        addr_nxt = cyc.addr[18:1];
        dq_nxt = {cyc.addr[0], 7'h00, cyc.data};
        if (bm_r) dq_oe_nxt = 16'h8000;
        else dq_oe_nxt = 16'h0000;
        ce_nxt = 1'b0;
        idv_nxt = (op_r == FRS_OP_ID_HV);
        if (cyc.wr) begin
          if (!bm_r) dq_nxt[15:8] = wd_r[15:8];
          // Drive data only with the output gate high to avoid contention
          dq_oe_nxt[7:0] = 8'hFF;
          if (!bm_r && op_r == FRS_OP_WRITE) dq_oe_nxt[15:8] = 8'hFF;
          we_nxt = 1'b0;
          cnt_nxt = TWP_CYC;
          st_nxt = FRS_ST_WR_LOW;
        end else begin
          oe_nxt = 1'b0;
          cnt_nxt = ACCESS_DELAY_CYC;
          st_nxt = FRS_ST_RD_WAIT;
        end
      end
      FRS_ST_WR_LOW: begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          we_nxt = 1'b1;
          ce_nxt = 1'b1;
          dq_oe_nxt = {bm_r, 15'h0000};
          cnt_nxt = TWPH_CYC;
          st_nxt = FRS_ST_GAP;
        end
      end
      FRS_ST_RD_WAIT: begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          rdata_nxt = dq_i;
          // Byte-mode reads and identifier reads keep the low byte only
          if (bm_r || op_r != FRS_OP_READ) rdata_nxt[15:8] = 8'h00;
          oe_nxt = 1'b1;
          ce_nxt = 1'b1;
          cnt_nxt = TWPH_CYC;
          st_nxt = FRS_ST_GAP;
        end
      end
      FRS_ST_GAP: begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          if (cyc.last) begin
            idv_nxt = 1'b0;
            done_nxt = 1'b1;
            st_nxt = FRS_ST_IDLE;
          end else begin
            step_nxt = step_r + 3'h1;
            st_nxt = FRS_ST_BUS;
          end
        end
      end
      FRS_ST_RST_LOW: begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          frst_nxt = 1'b1;
          cnt_nxt = busy_rst_r ? TRDY_BUSY_CYC : TRDY_IDLE_CYC;
          st_nxt = FRS_ST_RST_RDY;
        end
      end
      FRS_ST_RST_RDY: begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001 || (busy_rst_r && ready_busy_i)) begin
          cnt_nxt = RESET_HIGH_TO_READ_CYC;
          st_nxt = FRS_ST_RST_RH;
        end
      end
      FRS_ST_RST_RH: begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          done_nxt = 1'b1;
          st_nxt = FRS_ST_IDLE;
        end
      end
    endcase
    ready_nxt = (st_nxt == FRS_ST_IDLE);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= FRS_ST_IDLE;
      op_r <= FRS_OP_READ;
      sel_r <= FRS_ID_MAKER;
      cnt_r <= 16'h0000;
      step_r <= 3'h0;
      ba_r <= 19'h00000;
      wd_r <= 16'h0000;
      bm_r <= 1'b0;
      busy_rst_r <= 1'b0;
      ready_o <= 1'b1;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      sector_o <= 4'h0;
      restart_needed_o <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      flash_rst_n_o <= 1'b1;
      byte_n_o <= 1'b1;
      id_voltage_en_o <= 1'b0;
      addr_o <= 18'h00000;
      dq_o <= 16'h0000;
      dq_oe_o <= 16'h0000;
    end else if (en_i) begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      sel_r <= sel_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      ba_r <= ba_nxt;
      wd_r <= wd_nxt;
      bm_r <= bm_nxt;
      busy_rst_r <= busy_rst_nxt;
      ready_o <= ready_nxt;
      done_o <= done_nxt;
      rdata_o <= rdata_nxt;
      sector_o <= sector_nxt;
      restart_needed_o <= restart_nxt;
      ce_n_o <= ce_nxt;
      oe_n_o <= oe_nxt;
      we_n_o <= we_nxt;
      flash_rst_n_o <= frst_nxt;
      byte_n_o <= ~bm_nxt;
      id_voltage_en_o <= idv_nxt;
      addr_o <= addr_nxt;
      dq_o <= dq_nxt;
      dq_oe_o <= dq_oe_nxt;
    end
  end

  // Helper counters for the checks below
  logic [15:0] lo_cnt, hi_cnt;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'hFFFF;
    end else if (en_i) begin
      lo_cnt <= flash_rst_n_o ? 16'h0000 : lo_cnt + 16'h0001;
      hi_cnt <= !flash_rst_n_o ? 16'h0000 : (hi_cnt == 16'hFFFF ? hi_cnt : hi_cnt + 16'h0001);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  rst_pulse_width_a: assert property (
    $rose(flash_rst_n_o) |-> $past(lo_cnt) + 16'h0001 >= RESET_PULSE_MIN_CYC)
    else $error("flash reset pulse shorter than minimum");
  read_after_reset_a: assert property (
    $fell(oe_n_o) |-> hi_cnt >= RESET_HIGH_TO_READ_CYC)
    else $error("read started before reset-high-to-read elapsed");
  restart_flag_a: assert property (
    $fell(flash_rst_n_o) && !$past(ready_busy_i) |-> restart_needed_o)
    else $error("reset during busy did not flag a restart");
  hv_select_pins_a: assert property (
    id_voltage_en_o && !oe_n_o |-> !addr_o[6] && we_n_o)
    else $error("high-voltage read with wrong select pins");
  protect_addr_a: assert property (
    !oe_n_o && sel_r == FRS_ID_PROTECT && op_r != FRS_OP_READ |-> addr_o[1])
    else $error("protect verify without A1 high");
  cmd_no_hv_a: assert property (op_r == FRS_OP_ID_CMD && !ce_n_o |-> !id_voltage_en_o)
    else $error("command autoselect drove identification voltage");
  no_contention_a: assert property (dq_oe_o[7:0] != 8'h00 |-> oe_n_o && !we_n_o)
    else $error("host drives data while output gate active");
  id_exit_a: assert property (
    op_r == FRS_OP_ID_CMD && $rose(done_o) |-> $past(dq_o[7:0], 1) == `FRS_EXIT_DATA)
    else $error("command autoselect ended without exit command");

  hwreset_c: cover property ($rose(flash_rst_n_o) ##[1:1000] done_o);
  id_cmd_c: cover property (op_r == FRS_OP_ID_CMD && done_o);
  hv_read_c: cover property (id_voltage_en_o && !oe_n_o);
  busy_reset_c: cover property (busy_rst_r && st_r == FRS_ST_RST_RDY && ready_busy_i);
endmodule : frs_host

// ### frs_map.svh
// Timing, address and command constants for the boot-sector flash host controller
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH
`define FRS_CLK_NS 50
`define FRS_ACCESS_DELAY_NS 100
`define FRS_RESET_PULSE_MIN_NS 500
`define FRS_RESET_HIGH_TO_READ_NS 50
`define FRS_TRDY_BUSY_NS 20000
`define FRS_TRDY_IDLE_NS 500
`define FRS_TWP_NS 50
`define FRS_TWPH_NS 50
`define FRS_UNLOCK_ADDR1 18'h00555
`define FRS_UNLOCK_ADDR2 18'h002AA
`define FRS_UNLOCK_DATA1 8'hAA
`define FRS_UNLOCK_DATA2 8'h55
`define FRS_AUTOSEL_DATA 8'h90
`define FRS_EXIT_DATA 8'hF0
`define FRS_ID_MAKER_OFF 3'h0
`define FRS_ID_PART_OFF 3'h2
`define FRS_ID_PROT_OFF 3'h4
`define FRS_SECTOR_SELECT_LSB 13
`endif

// ### frs_pkg.sv
// Types shared by the boot-sector flash host controller
package frs_pkg;
  typedef enum logic [2:0] {
    FRS_OP_READ,
    FRS_OP_WRITE,
    FRS_OP_HWRESET,
    FRS_OP_ID_CMD,
    FRS_OP_ID_HV
  } frs_op_t;
  typedef enum logic [1:0] {
    FRS_ID_MAKER,
    FRS_ID_PART,
    FRS_ID_PROTECT
  } frs_id_sel_t;
  typedef enum logic [2:0] {
    FRS_ST_IDLE,
    FRS_ST_BUS,
    FRS_ST_WR_LOW,
    FRS_ST_RD_WAIT,
    FRS_ST_GAP,
    FRS_ST_RST_LOW,
    FRS_ST_RST_RDY,
    FRS_ST_RST_RH
  } frs_state_t;
  typedef struct packed {
    logic wr;
    logic [18:0] addr;
    logic [7:0] data;
    logic last;
  } frs_cycle_t;
endpackage : frs_pkg

// ### frs_sector_decode.sv
// Sector index decode from the upper address bits, top or bottom boot layout
module frs_sector_decode (
  input wire logic boot_top_i,
  input wire logic [5:0] sector_select_address_i,
  output logic [3:0] sector_o
);
  import frs_pkg::*;
  always_comb begin
    if (boot_top_i) begin
      if (sector_select_address_i[5:3] != 3'h7) begin
        sector_o = {1'b0, sector_select_address_i[5:3]};
      end else if (!sector_select_address_i[2]) begin
        sector_o = 4'h7;
      end else if (!sector_select_address_i[1]) begin
        sector_o = 4'h8 + {3'h0, sector_select_address_i[0]};
      end else begin
        sector_o = 4'hA;
      end
    end else begin
      if (sector_select_address_i[5:3] != 3'h0) begin
        sector_o = 4'h3 + {1'b0, sector_select_address_i[5:3]};
      end else if (sector_select_address_i[2]) begin
        sector_o = 4'h3;
      end else if (!sector_select_address_i[1]) begin
        sector_o = 4'h0;
      end else begin
        sector_o = 4'h1 + {3'h0, sector_select_address_i[0]};
      end
    end
  end
endmodule : frs_sector_decode
